/* File: rtl/special_cmd_pkg.sv */
package special_cmd_pkg;
  // ==========================================================
  // message framing
  localparam logic [5:0] FRAME_BITS = 6'h20;
  localparam logic [7:0] MSG_PREFIX = 8'h10;
  localparam logic [31:0] REPLY_FLAG = 32'h8000_0000;
  localparam logic [31:0] IDLE_REPLY = 32'hFFFF_FFFF;
  // ==========================================================
  // special command codes (second message byte)
  localparam logic [7:0] CMD_CLR_WARN = 8'h03;
  localparam logic [7:0] CMD_ACTIVATE = 8'h04;
  localparam logic [7:0] CMD_RESCAN = 8'h05;
  localparam logic [7:0] CMD_EXT_ON = 8'hCD;
  localparam logic [7:0] CMD_EXT_OFF = 8'hCE;
  localparam logic [7:0] CMD_WAKE = 8'hFA;
  localparam logic [7:0] CMD_CLR_CAL_A = 8'hF3;
  localparam logic [7:0] CMD_CLR_CAL_B = 8'hF4;
  localparam logic [7:0] CMD_WR_CAL_A = 8'hF5;
  localparam logic [7:0] CMD_WR_CAL_B = 8'hF6;
  // ==========================================================
  // scratch map
  localparam logic [11:0] EXT_OFFSET = 12'h800;
  localparam logic [11:0] ADDR_CLEAR_BUSY = 12'hDC3;
  localparam logic [11:0] ADDR_WRITE_A_BUSY = 12'hDC4;
  localparam logic [11:0] ADDR_WRITE_B_BUSY = 12'hDC6;
  localparam logic [7:0] FLAG_BUSY = 8'h01;
  localparam logic [7:0] FLAG_IDLE = 8'h00;
  localparam logic [7:0] MODE_OFF = 8'h00;
  localparam logic [7:0] MODE_FW = 8'h01;
  localparam logic [7:0] WARN_NONE = 8'h00;
  // ==========================================================
  // nonvolatile operation codes
  localparam logic [1:0] NV_CLR_A = 2'h0;
  localparam logic [1:0] NV_CLR_B = 2'h1;
  localparam logic [1:0] NV_WR_A = 2'h2;
  localparam logic [1:0] NV_WR_B = 2'h3;
  // ==========================================================
  // timing
  localparam int unsigned CLOCK_HZ = 125000000;
  localparam int unsigned OFF_TIME_MS = 1000;
  localparam int unsigned WAKE_TIME_US = 1000;
  localparam int unsigned ACTIVE_TIME_MS = 100;
  localparam int unsigned OFF_CYCLES = (CLOCK_HZ / 1000) * OFF_TIME_MS;
  localparam int unsigned WAKE_CYCLES =
    ((CLOCK_HZ / 1000) * WAKE_TIME_US + 999) / 1000;
  localparam int unsigned ACTIVE_CYCLES =
    (CLOCK_HZ / 1000) * ACTIVE_TIME_MS;
  localparam int unsigned TIMER_BITS = 27;
endpackage

/* File: rtl/frame_if.sv */
`timescale 1ns/1ps
interface frame_if;
  logic msg_valid;
  logic [31:0] msg_word;
  logic [31:0] reply_word;
  modport shifter (output msg_valid, output msg_word, input reply_word);
  modport ctrl (input msg_valid, input msg_word, output reply_word);
endinterface // frame_if

/* File: rtl/spi_frame_shifter.sv */
`timescale 1ns/1ps
module spi_frame_shifter (
  input wire logic clock,
  input wire logic srst,
  input wire logic spi_sclk,
  input wire logic chip_select_line_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  frame_if.shifter frm
);
  // ==========================================================
  // pin synchronisers: first stage feeds only the second
  logic [2:0] meta_reg, meta_next;
  logic [2:0] sync_reg, sync_next;
  logic sclk_d_reg, sclk_d_next;
  logic cs_d_reg, cs_d_next;
  logic [5:0] bit_cnt_reg, bit_cnt_next;
  logic [31:0] rx_reg, rx_next;
  logic [31:0] tx_reg, tx_next;
  logic valid_reg, valid_next;
  logic [31:0] word_reg, word_next;
  logic rise, fall, sel_start, sel_end;

  always_comb begin
    meta_next = {spi_sclk, chip_select_line_n, spi_mosi};
    sync_next = meta_reg;
    sclk_d_next = sync_reg[2];
    cs_d_next = sync_reg[1];
    rise = sync_reg[2] & ~sclk_d_reg;
    fall = ~sync_reg[2] & sclk_d_reg;
    sel_start = ~sync_reg[1] & cs_d_reg;
    sel_end = sync_reg[1] & ~cs_d_reg;
    bit_cnt_next = bit_cnt_reg;
    rx_next = rx_reg;
    tx_next = tx_reg;
    valid_next = 1'b0;
    word_next = word_reg;
    if (sel_start) begin
      bit_cnt_next = 6'h00;
      tx_next = frm.reply_word;
    end else if (!sync_reg[1]) begin
      if (rise && bit_cnt_reg != special_cmd_pkg::FRAME_BITS) begin
        rx_next = {rx_reg[30:0], sync_reg[0]};
        bit_cnt_next = bit_cnt_reg + 6'h01;
      end
      if (fall) begin
        tx_next = {tx_reg[30:0], 1'b1};
      end
    end
    // short frames carry no message and are dropped
    if (sel_end && bit_cnt_reg == special_cmd_pkg::FRAME_BITS) begin
      valid_next = 1'b1;
      word_next = rx_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      // idle levels (sclk low, select high) so no false edge follows reset
      meta_reg <= 3'h2;
      sync_reg <= 3'h2;
      sclk_d_reg <= 1'b0;
      cs_d_reg <= 1'b1;
      bit_cnt_reg <= 6'h00;
      rx_reg <= 32'h0000_0000;
      tx_reg <= special_cmd_pkg::IDLE_REPLY;
      valid_reg <= 1'b0;
      word_reg <= 32'h0000_0000;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      sclk_d_reg <= sclk_d_next;
      cs_d_reg <= cs_d_next;
      bit_cnt_reg <= bit_cnt_next;
      rx_reg <= rx_next;
      tx_reg <= tx_next;
      valid_reg <= valid_next;
      word_reg <= word_next;
    end
  end

  assign spi_miso = tx_reg[31];
  assign frm.msg_valid = valid_reg;
  assign frm.msg_word = word_reg;

  a_short_frame: assert property (@(posedge clock) disable iff (srst)
    sel_end && bit_cnt_reg != special_cmd_pkg::FRAME_BITS |=> !valid_reg)
    else $error("short frame produced a message");
endmodule // spi_frame_shifter

/* File: rtl/spi_special_command_handler.sv */
`timescale 1ns/1ps
// Functional notes
// - a new output mode waits for the activate message.
// - 10 03 00 00 clears the warning code, reply 90 03 00 00.
// - 10 04 00 00 applies the pending output mode.
// - 10 05 00 00 starts a frequency rescan, linearizing continues.
// - 10 CD 00 00 adds 0x800 to later scratch read addresses.
// - 10 CE 00 00 stops adding the read address offset.
// - duty-cycled feedback powers down for 1 s between intervals.
// - 10 FA 00 00 wakes from power-down within about 1 ms.
// - 10 F3 00 00 erases set A, raising the clear-busy flag.
// - 10 F4 00 00 erases set B, same clear-busy flag.
// - after a calibration store the device runs in smooth mode.
// - all-zero calibration at reset selects optimized mode.
// - mode 00 disables output and freezes; 01 gives firmware control.
module spi_special_command_handler #(
  parameter int unsigned OFF_CYCLES = special_cmd_pkg::OFF_CYCLES,
  parameter int unsigned WAKE_CYCLES = special_cmd_pkg::WAKE_CYCLES,
  parameter int unsigned ACTIVE_CYCLES = special_cmd_pkg::ACTIVE_CYCLES
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic spi_sclk,
  input wire logic chip_select_line_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  input wire logic [7:0] output_mode_written,
  input wire logic fw_output_allow,
  input wire logic warning_event,
  input wire logic [7:0] warning_value,
  input wire logic duty_cycle_enable,
  input wire logic cal_values_zero,
  input wire logic nv_op_done,
  input wire logic [11:0] scratch_rd_addr,
  output logic [11:0] scratch_eff_addr,
  output logic [7:0] scratch_rd_data,
  output logic [7:0] warning_code,
  output logic [7:0] output_mode_active,
  output logic rf_output,
  output logic adaptation_frozen,
  output logic rescan_start,
  output logic power_down,
  output logic nv_op_start,
  output logic [1:0] nv_op_code,
  output logic smooth_mode,
  output logic [7:0] cal_clear_busy_flag,
  output logic [7:0] cal_write_a_busy_flag,
  output logic [7:0] cal_write_b_busy_flag
);
  localparam int unsigned TB = special_cmd_pkg::TIMER_BITS;
  localparam logic [TB-1:0] OFF_LAST = TB'(OFF_CYCLES - 1);
  localparam logic [TB-1:0] WAKE_LAST = TB'(WAKE_CYCLES - 1);
  localparam logic [TB-1:0] ACT_LAST = TB'(ACTIVE_CYCLES - 1);

  typedef enum logic [1:0] {PWR_ACTIVE, PWR_OFF, PWR_WAKING} pwr_state_t;

  frame_if frm ();

  spi_frame_shifter u_shifter (
    .clock(clock),
    .srst(srst),
    .spi_sclk(spi_sclk),
    .chip_select_line_n(chip_select_line_n),
    .spi_mosi(spi_mosi),
    .spi_miso(spi_miso),
    .frm(frm.shifter)
  );

  // ==========================================================
  // message decode
  logic [7:0] code;
  logic special, known;
  always_comb begin
    code = frm.msg_word[23:16];
    special = frm.msg_valid
      && frm.msg_word[31:24] == special_cmd_pkg::MSG_PREFIX
      && frm.msg_word[15:0] == 16'h0000;
    case (code)
      special_cmd_pkg::CMD_CLR_WARN, special_cmd_pkg::CMD_ACTIVATE,
      special_cmd_pkg::CMD_RESCAN, special_cmd_pkg::CMD_EXT_ON,
      special_cmd_pkg::CMD_EXT_OFF, special_cmd_pkg::CMD_WAKE,
      special_cmd_pkg::CMD_CLR_CAL_A, special_cmd_pkg::CMD_CLR_CAL_B,
      special_cmd_pkg::CMD_WR_CAL_A, special_cmd_pkg::CMD_WR_CAL_B: begin
        known = special;
      end
      default: begin
        known = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // control and status state
  logic [31:0] reply_reg, reply_next;
  logic [7:0] warn_reg, warn_next;
  logic [7:0] mode_reg, mode_next;
  logic rf_reg, rf_next;
  logic frozen_reg, frozen_next;
  logic rescan_reg, rescan_next;
  logic ext_reg, ext_next;
  logic [11:0] eff_reg, eff_next;
  logic [7:0] rdata_reg, rdata_next;
  logic nv_start_reg, nv_start_next;
  logic [1:0] nv_code_reg, nv_code_next;
  logic [7:0] clr_busy_reg, clr_busy_next;
  logic [7:0] wa_busy_reg, wa_busy_next;
  logic [7:0] wb_busy_reg, wb_busy_next;
  logic smooth_reg, smooth_next;
  logic init_reg, init_next;
  logic any_busy;

  always_comb begin
    reply_next = reply_reg;
    warn_next = warn_reg;
    mode_next = mode_reg;
    rescan_next = 1'b0;
    ext_next = ext_reg;
    nv_start_next = 1'b0;
    nv_code_next = nv_code_reg;
    clr_busy_next = clr_busy_reg;
    wa_busy_next = wa_busy_reg;
    wb_busy_next = wb_busy_reg;
    smooth_next = smooth_reg;
    init_next = 1'b0;
    any_busy = clr_busy_reg != special_cmd_pkg::FLAG_IDLE
      || wa_busy_reg != special_cmd_pkg::FLAG_IDLE
      || wb_busy_reg != special_cmd_pkg::FLAG_IDLE;
    // strap caught on the first edge after reset release
    if (init_reg) begin
      smooth_next = !cal_values_zero;
    end
    // a finished store leaves the device in smooth mode
    if (nv_op_done && any_busy) begin
      if (wa_busy_reg != special_cmd_pkg::FLAG_IDLE
          || wb_busy_reg != special_cmd_pkg::FLAG_IDLE) begin
        smooth_next = 1'b1;
      end
      clr_busy_next = special_cmd_pkg::FLAG_IDLE;
      wa_busy_next = special_cmd_pkg::FLAG_IDLE;
      wb_busy_next = special_cmd_pkg::FLAG_IDLE;
    end
    if (frm.msg_valid) begin
      // reply is presented in the next four-byte frame
      reply_next = known ? (frm.msg_word | special_cmd_pkg::REPLY_FLAG)
        : special_cmd_pkg::IDLE_REPLY;
    end
    if (known) begin
      case (code)
        special_cmd_pkg::CMD_CLR_WARN: begin
          warn_next = special_cmd_pkg::WARN_NONE;
        end
        special_cmd_pkg::CMD_ACTIVATE: begin
          mode_next = output_mode_written;
        end
        special_cmd_pkg::CMD_RESCAN: begin
          rescan_next = 1'b1;
        end
        special_cmd_pkg::CMD_EXT_ON: begin
          ext_next = 1'b1;
        end
        special_cmd_pkg::CMD_EXT_OFF: begin
          ext_next = 1'b0;
        end
        special_cmd_pkg::CMD_WAKE: begin
          rescan_next = 1'b0;
        end
        default: begin
          // one nonvolatile operation at a time; later ones are dropped
          if (!any_busy) begin
            nv_start_next = 1'b1;
            nv_code_next = code[1:0] + 2'h1;
            if (code == special_cmd_pkg::CMD_WR_CAL_A) begin
              wa_busy_next = special_cmd_pkg::FLAG_BUSY;
            end else if (code == special_cmd_pkg::CMD_WR_CAL_B) begin
              wb_busy_next = special_cmd_pkg::FLAG_BUSY;
            end else begin
              clr_busy_next = special_cmd_pkg::FLAG_BUSY;
            end
          end
        end
      endcase
    end
    // a new warning wins over a clear in the same cycle
    if (warning_event) begin
      warn_next = warning_value;
    end
    // output stage
    rf_next = mode_reg == special_cmd_pkg::MODE_FW && fw_output_allow;
    frozen_next = mode_reg == special_cmd_pkg::MODE_OFF;
    eff_next = ext_reg ? scratch_rd_addr + special_cmd_pkg::EXT_OFFSET
      : scratch_rd_addr;
    case (eff_reg)
      special_cmd_pkg::ADDR_CLEAR_BUSY: rdata_next = clr_busy_reg;
      special_cmd_pkg::ADDR_WRITE_A_BUSY: rdata_next = wa_busy_reg;
      special_cmd_pkg::ADDR_WRITE_B_BUSY: rdata_next = wb_busy_reg;
      default: rdata_next = special_cmd_pkg::FLAG_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      reply_reg <= special_cmd_pkg::IDLE_REPLY;
      warn_reg <= special_cmd_pkg::WARN_NONE;
      mode_reg <= special_cmd_pkg::MODE_OFF;
      rf_reg <= 1'b0;
      frozen_reg <= 1'b1;
      rescan_reg <= 1'b0;
      ext_reg <= 1'b0;
      eff_reg <= 12'h000;
      rdata_reg <= special_cmd_pkg::FLAG_IDLE;
      nv_start_reg <= 1'b0;
      nv_code_reg <= special_cmd_pkg::NV_CLR_A;
      clr_busy_reg <= special_cmd_pkg::FLAG_IDLE;
      wa_busy_reg <= special_cmd_pkg::FLAG_IDLE;
      wb_busy_reg <= special_cmd_pkg::FLAG_IDLE;
      smooth_reg <= 1'b0;
      init_reg <= 1'b1;
    end else begin
      reply_reg <= reply_next;
      warn_reg <= warn_next;
      mode_reg <= mode_next;
      rf_reg <= rf_next;
      frozen_reg <= frozen_next;
      rescan_reg <= rescan_next;
      ext_reg <= ext_next;
      eff_reg <= eff_next;
      rdata_reg <= rdata_next;
      nv_start_reg <= nv_start_next;
      nv_code_reg <= nv_code_next;
      clr_busy_reg <= clr_busy_next;
      wa_busy_reg <= wa_busy_next;
      wb_busy_reg <= wb_busy_next;
      smooth_reg <= smooth_next;
      init_reg <= init_next;
    end
  end

  // ==========================================================
  // duty-cycled power sequencing
  pwr_state_t pwr_reg, pwr_next;
  logic [TB-1:0] timer_reg, timer_next;
  logic pd_reg, pd_next;

  always_comb begin
    pwr_next = pwr_reg;
    timer_next = timer_reg + TB'(1);
    case (pwr_reg)
      PWR_ACTIVE: begin
        if (!duty_cycle_enable) begin
          timer_next = '0;
        end else if (timer_reg == ACT_LAST) begin
          pwr_next = PWR_OFF;
          timer_next = '0;
        end
      end
      PWR_OFF: begin
        if (known && code == special_cmd_pkg::CMD_WAKE) begin
          pwr_next = PWR_WAKING;
          timer_next = '0;
        end else if (timer_reg == OFF_LAST) begin
          pwr_next = PWR_WAKING;
          timer_next = '0;
        end
      end
      PWR_WAKING: begin
        if (timer_reg == WAKE_LAST) begin
          pwr_next = PWR_ACTIVE;
          timer_next = '0;
        end
      end
      default: begin
        pwr_next = PWR_ACTIVE;
        timer_next = '0;
      end
    endcase
    pd_next = pwr_next == PWR_OFF;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pwr_reg <= PWR_ACTIVE;
      timer_reg <= '0;
      pd_reg <= 1'b0;
    end else begin
      pwr_reg <= pwr_next;
      timer_reg <= timer_next;
      pd_reg <= pd_next;
    end
  end

  assign frm.reply_word = reply_reg;
  assign scratch_eff_addr = eff_reg;
  assign scratch_rd_data = rdata_reg;
  assign warning_code = warn_reg;
  assign output_mode_active = mode_reg;
  assign rf_output = rf_reg;
  assign adaptation_frozen = frozen_reg;
  assign rescan_start = rescan_reg;
  assign power_down = pd_reg;
  assign nv_op_start = nv_start_reg;
  assign nv_op_code = nv_code_reg;
  assign smooth_mode = smooth_reg;
  assign cal_clear_busy_flag = clr_busy_reg;
  assign cal_write_a_busy_flag = wa_busy_reg;
  assign cal_write_b_busy_flag = wb_busy_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  a_warn_clear: assert property (known && code == 8'h03 && !warning_event
    |=> warn_reg == 8'h00) else $error("warning not cleared");
  a_mode_held: assert property (!(known && code == 8'h04)
    |=> $stable(mode_reg)) else $error("mode changed early");
  a_mode_apply: assert property (known && code == 8'h04
    |=> mode_reg == $past(output_mode_written))
    else $error("mode not applied");
  a_rescan_pulse: assert property (known && code == 8'h05
    |=> rescan_reg ##1 !rescan_reg) else $error("no rescan");
  a_ext_offset: assert property (ext_reg && $stable(ext_reg)
    |=> eff_reg == $past(scratch_rd_addr) + 12'h800)
    else $error("offset missing");
  a_ext_off: assert property (known && code == 8'hCE
    |=> !ext_reg) else $error("extended read stuck");
  a_wake_time: assert property (known && code == 8'hFA
    && pwr_reg == PWR_OFF |=> !pd_reg)
    else $error("wake ignored");
  a_clr_busy: assert property (known && (code == 8'hF3 || code == 8'hF4)
    && !any_busy && !nv_op_done |=> clr_busy_reg == 8'h01 && nv_start_reg)
    else $error("clear busy not set");
  a_write_a: assert property (known && code == 8'hF5 && !any_busy
    |=> wa_busy_reg == 8'h01 ##1 (wa_busy_reg == 8'h01 || smooth_reg))
    else $error("write-A flag wrong");
  a_write_b: assert property (known && code == 8'hF6 && !any_busy
    |=> wb_busy_reg == 8'h01 && nv_code_reg == 2'h3)
    else $error("write-B flag wrong");
  a_reply_echo: assert property (known
    |=> reply_reg == {1'b1, $past(frm.msg_word[30:0])})
    else $error("reply not echoed");
  a_mode_out: assert property (mode_reg == 8'h00
    |=> !rf_reg && frozen_reg) else $error("output not off");
  a_strap: assert property (init_reg |=> smooth_reg == !$past(cal_values_zero))
    else $error("strap not caught");

  c_activate: cover property (known && code == 8'h04);
  c_wake: cover property (pwr_reg == PWR_OFF && known && code == 8'hFA);
  c_write_done: cover property (wa_busy_reg == 8'h01 && nv_op_done);
endmodule // spi_special_command_handler

/* File: testbench/spi_host_model.sv */
`timescale 1ns/1ps
// ==========================================================
// spi host, mode 0, 64 ns serial clock
module spi_host_model (
  input wire logic clock,
  input wire logic spi_miso,
  output logic spi_sclk,
  output logic chip_select_line_n,
  output logic spi_mosi
);
  // serial clock stands low between frames
  initial begin
    spi_sclk = 1'b0;
    chip_select_line_n = 1'b1;
    spi_mosi = 1'b0;
  end

  // nbits below 32 only to provoke a dropped frame
  task automatic frame(input logic [31:0] tx, input int nbits,
                       output logic [31:0] rx);
    rx = 32'h0000_0000;
    @(posedge clock);
    #1;
    chip_select_line_n = 1'b0;
    #32;
    for (int i = 0; i < nbits; i++) begin
      spi_mosi = tx[31 - i];
      #32 spi_sclk = 1'b1;
      rx = {rx[30:0], spi_miso};
      #32 spi_sclk = 1'b0;
    end
    #32 chip_select_line_n = 1'b1;
    // released line carries no stale bit
    spi_mosi = ~spi_mosi;
    #96;
  endtask
endmodule // spi_host_model

/* File: testbench/spi_special_command_handler_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin \
  mismatches++; $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end
module spi_special_command_handler_tb;
  logic clock = 1'b0, srst = 1'b1, sclk, cs_n, mosi, miso;
  logic [7:0] mode_wr = 8'h00, warn_val = 8'h00;
  logic allow = 1'b1, warn_ev = 1'b0, duty = 1'b0, cal_zero = 1'b1;
  logic nv_done = 1'b0;
  logic [11:0] rd_addr = 12'h000, eff_addr;
  logic [7:0] rd_data, warn_code, mode_act, f_clr, f_wa, f_wb;
  logic rf_out, frozen, rescan, pdown, nv_start, smooth;
  logic [1:0] nv_code;
  int mismatches = 0, total_checks = 0, cycles = 0, rescans = 0, starts = 0;
  localparam logic [7:0] nv_cmds [4] = '{8'hF3, 8'hF4, 8'hF5, 8'hF6};
  localparam logic [11:0] nv_addr [4] = '{12'hDC3, 12'hDC3, 12'hDC4, 12'hDC6};
  localparam logic [23:0] nv_flags [4] =
    '{24'h01_0000, 24'h01_0000, 24'h00_0100, 24'h00_0001};

  always #4 clock = ~clock;

  spi_host_model u_host (.clock(clock), .spi_miso(miso), .spi_sclk(sclk),
    .chip_select_line_n(cs_n), .spi_mosi(mosi));

  spi_special_command_handler #(.OFF_CYCLES(2000), .WAKE_CYCLES(20),
    .ACTIVE_CYCLES(300)) u_dut (.clock(clock), .srst(srst), .spi_sclk(sclk),
    .chip_select_line_n(cs_n), .spi_mosi(mosi), .spi_miso(miso),
    .output_mode_written(mode_wr), .fw_output_allow(allow),
    .warning_event(warn_ev), .warning_value(warn_val),
    .duty_cycle_enable(duty), .cal_values_zero(cal_zero),
    .nv_op_done(nv_done), .scratch_rd_addr(rd_addr),
    .scratch_eff_addr(eff_addr), .scratch_rd_data(rd_data),
    .warning_code(warn_code), .output_mode_active(mode_act),
    .rf_output(rf_out), .adaptation_frozen(frozen), .rescan_start(rescan),
    .power_down(pdown), .nv_op_start(nv_start), .nv_op_code(nv_code),
    .smooth_mode(smooth), .cal_clear_busy_flag(f_clr),
    .cal_write_a_busy_flag(f_wa), .cal_write_b_busy_flag(f_wb));

  // ==========================================================
  // pulse counters and hang guard
  always @(posedge clock) begin
    cycles++;
    if (rescan === 1'b1) rescans++;
    if (nv_start === 1'b1) starts++;
    if (cycles == 30000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic send(input logic [31:0] w);
    logic [31:0] r;
    u_host.frame(w, 32, r);
  endtask

  // reply of the previous message arrives in the next frame
  task automatic reply(input logic [31:0] exp);
    logic [31:0] r;
    u_host.frame(32'h0000_0000, 32, r);
    `CHK("reply", exp, r)
  endtask

  task automatic read_flag(input logic [11:0] a, output logic [7:0] d);
    rd_addr = a;
    tick(3);
    d = rd_data;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    logic [7:0] d;
    logic [31:0] r;
    tick(2);
    srst = 1'b0;
    tick(4);
    `CHK("smooth", 1'b0, smooth)
    `CHK("frozen", 1'b1, frozen)
    $display("test reset done");
    // ==========================================================
    warn_val = 8'h2A;
    warn_ev = 1'b1;
    tick(1);
    warn_ev = 1'b0;
    tick(1);
    `CHK("warn", 8'h2A, warn_code)
    send(32'h1003_0000);
    `CHK("warn", 8'h00, warn_code)
    reply(32'h9003_0000);
    $display("test warning done");
    // ==========================================================
    mode_wr = 8'h01;
    tick(4);
    `CHK("mode", 8'h00, mode_act)
    send(32'h1004_0000);
    `CHK("mode", 8'h01, mode_act)
    `CHK("rf", 1'b1, rf_out)
    `CHK("frozen", 1'b0, frozen)
    allow = 1'b0;
    tick(2);
    `CHK("rf", 1'b0, rf_out)
    allow = 1'b1;
    tick(2);
    `CHK("rf", 1'b1, rf_out)
    reply(32'h9004_0000);
    mode_wr = 8'h00;
    send(32'h1004_0000);
    `CHK("rf", 1'b0, rf_out)
    `CHK("frozen", 1'b1, frozen)
    $display("test output mode done");
    // ==========================================================
    send(32'h1005_0000);
    `CHK("rescans", 1, rescans)
    reply(32'h9005_0000);
    $display("test rescan done");
    // ==========================================================
    rd_addr = 12'h5C3;
    tick(3);
    `CHK("eff", 12'h5C3, eff_addr)
    send(32'h10CD_0000);
    tick(2);
    `CHK("eff", 12'hDC3, eff_addr)
    u_host.frame(32'h10CE_0000, 16, r);
    reply(32'h90CD_0000);
    `CHK("eff", 12'hDC3, eff_addr)
    send(32'h10CE_0000);
    tick(2);
    `CHK("eff", 12'h5C3, eff_addr)
    reply(32'h90CE_0000);
    $display("test extended read done");
    // ==========================================================
    for (int i = 0; i < 4; i++) begin
      send({8'h10, nv_cmds[i], 16'h0000});
      `CHK("code", 2'(i), nv_code)
      `CHK("starts", i + 1, starts)
      read_flag(nv_addr[i], d);
      `CHK("flag", 8'h01, d)
      `CHK("flags", nv_flags[i], {f_clr, f_wa, f_wb})
      reply({8'h90, nv_cmds[i], 16'h0000});
      nv_done = 1'b1;
      tick(1);
      nv_done = 1'b0;
      for (int k = 0; k < 8 && d !== 8'h00; k++) read_flag(nv_addr[i], d);
      `CHK("flag", 8'h00, d)
      `CHK("flags", 24'h00_0000, {f_clr, f_wa, f_wb})
      `CHK("smooth", (i >= 2), smooth)
    end
    $display("test calibration done");
    // ==========================================================
    duty = 1'b1;
    for (int k = 0; k < 400 && pdown !== 1'b1; k++) tick(1);
    `CHK("pdown", 1'b1, pdown)
    tick(100);
    `CHK("pdown", 1'b1, pdown)
    send(32'h10FA_0000);
    `CHK("pdown", 1'b0, pdown)
    reply(32'h90FA_0000);
    duty = 1'b0;
    $display("test wake done");
    // ==========================================================
    // second reset with stored calibration present
    cal_zero = 1'b0;
    srst = 1'b1;
    tick(2);
    srst = 1'b0;
    tick(4);
    `CHK("smooth", 1'b1, smooth)
    `CHK("pdown", 1'b0, pdown)
    reply(32'hFFFF_FFFF);
    send(32'h1077_0000);
    reply(32'hFFFF_FFFF);
    $display("test second reset done");
    close_out();
  end
endmodule // spi_special_command_handler_tb
